// ===== adc_dev.sv
/*
 * Digital side of a 10-bit two-step converter with an 8-way input
 * multiplexer. Analog levels arrive as 12-bit words on the user side.
 * Assumes the converter clock, the write strobe and the address pins come
 * from the far end without timing relation to clk; all pass two flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"

// Functional notes
// RULE_01 - Quantise into 1024 evenly spaced codes.
// RULE_02 - Overflow bit generated beside ten data bits.
// RULE_03 - Conversion synchronous, done within two periods.
// RULE_04 - Clock high balances, clock low samples.
// RULE_05 - Rising edge plus aperture delay samples.
// RULE_06 - Coarse picks subrange, fine resolves next high.
// RULE_07 - Host discards result when ladder moves.
// RULE_08 - Discarded sample may use minimum low time.
// RULE_09 - Overflow at positive reference, data untouched.
// RULE_10 - Out of range clamps to zero or full.
// RULE_11 - Host may use any legal duty cycle.
// RULE_12 - Continuous or pulsed clock; idle stays balanced.
// RULE_13 - Host-selected one of eight inputs converted.
// RULE_14 - Code is 1024 times input over span.
// RULE_15 - Data valid one and a half cycles later.
// RULE_16 - Host writes address with low write strobe.
// RULE_17 - Data and overflow held in register stage.
module adc_dev
   import adc_pkg::*;
(
   // System
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Link
   adc_link_if.dev                    link,
   // Analog side
   input  wire logic [7:0][11:0]      ain,
   input  wire adc_level_t            vref_pos,
   input  wire adc_level_t            vref_neg,
   // Status
   output logic [2:0]                 active_chan,
   output logic                       data_update
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic       clk_s1;
      logic       clk_s2;
      logic       clk_d;
      logic       wr_s1;
      logic       wr_s2;
      logic       wr_d;
      adc_chan_t  sel_s1;
      adc_chan_t  sel_s2;
      adc_chan_t  chan;
      adc_count_t ap_cnt;
      logic       ap_busy;
      adc_level_t held;
      logic       held_v;
      adc_half_t  coarse;
      logic       coarse_ovf;
      adc_code_t  stage1;
      logic       stage1_ovf;
      logic       stage1_v;
      adc_code_t  stage2;
      logic       stage2_ovf;
      logic       stage2_v;
      adc_code_t  dout;
      logic       ovf_out;
      logic       upd;
   } adc_dev_state_t;

   // The link clock idles high, which is the balance phase.
   localparam adc_dev_state_t RESET_STATE = '{
      clk_s1:     1'b1,
      clk_s2:     1'b1,
      clk_d:      1'b1,
      wr_s1:      1'b1,
      wr_s2:      1'b1,
      wr_d:       1'b1,
      default:    '0
   };

   adc_dev_state_t st_reg;
   adc_dev_state_t st_next;

   ////////////////////////////////////////////////////////////////////////
   // Conversion arithmetic

   // Full ten-bit conversion of one level against the given references.
   function automatic adc_code_t adc_convert(input adc_level_t vin,
                                             input adc_level_t vpos,
                                             input adc_level_t vneg);
      logic [11:0] span;
      logic [21:0] num;
      logic [21:0] quot;
      span = vpos - vneg;
      num  = '0;
      quot = '0;
      if (vin <= vneg || vpos <= vneg) begin
         adc_convert = '0;                                      // RULE_10
      end else begin
         num  = {vin - vneg, 10'h000};                          // RULE_14
         quot = num / {10'h000, span};                          // RULE_01
         if (quot >= 22'(`ADC_NUM_CODES)) begin
            adc_convert = `ADC_CODE_MAX;                        // RULE_10
         end else begin
            adc_convert = quot[9:0];
         end
      end
   endfunction

   // The overflow flag is a comparison of its own and never feeds the code.
   function automatic logic adc_overflow(input adc_level_t vin,
                                         input adc_level_t vpos);
      adc_overflow = (vin >= vpos);                             // RULE_09
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state

   logic      clk_rise;
   logic      clk_fall;
   logic      wr_rise;
   adc_code_t fine_full;
   adc_code_t coarse_full;
   adc_half_t fine;

   always_comb begin
      st_next = st_reg;

      // Two-stage synchronisers for every pin from the far end.
      st_next.clk_s1 = link.conv_clk;
      st_next.clk_s2 = st_reg.clk_s1;
      st_next.clk_d  = st_reg.clk_s2;
      st_next.wr_s1  = link.wr_n;
      st_next.wr_s2  = st_reg.wr_s1;
      st_next.wr_d   = st_reg.wr_s2;
      st_next.sel_s1 = {link.channel_select_bit2,
                        link.channel_select_bit1,
                        link.channel_select_bit0};
      st_next.sel_s2 = st_reg.sel_s1;

      clk_rise = st_reg.clk_s2 & ~st_reg.clk_d;                 // RULE_04
      clk_fall = ~st_reg.clk_s2 & st_reg.clk_d;                 // RULE_04
      wr_rise  = st_reg.wr_s2 & ~st_reg.wr_d;
      coarse_full = adc_convert(ain[st_reg.chan], vref_pos, vref_neg);

      // The address is taken at the end of the write pulse; the far end
      // holds it through that edge, so the synchronised copy is settled.
      if (wr_rise) begin
         st_next.chan = st_reg.sel_s2;                          // RULE_13
      end

      st_next.upd = 1'b0;

      // Aperture delay: the rising edge starts a short count and the
      // sample is taken when it runs out.
      if (clk_rise) begin
         st_next.ap_busy = 1'b1;                                // RULE_05
         st_next.ap_cnt  = adc_count_t'(`ADC_AP_CYC);
         // Second register of the output pipe.
         st_next.stage2     = st_reg.stage1;                    // RULE_15
         st_next.stage2_ovf = st_reg.stage1_ovf;
         st_next.stage2_v   = st_reg.stage1_v;
         st_next.stage1_v   = 1'b0;
      end else if (st_reg.ap_busy) begin
         if (st_reg.ap_cnt <= adc_count_t'(1)) begin
            st_next.ap_busy = 1'b0;
            // Sampling instant: coarse pass and overflow against the
            // ladder as it stands now.
            st_next.held = ain[st_reg.chan];                    // RULE_13
            st_next.held_v = 1'b1;
            st_next.coarse = coarse_full[9:`ADC_COARSE_LSB];    // RULE_06
            st_next.coarse_ovf = adc_overflow(ain[st_reg.chan],
                                              vref_pos);        // RULE_02
         end else begin
            st_next.ap_cnt = st_reg.ap_cnt - adc_count_t'(1);
         end
      end

      // Fine pass: runs against the ladder during the balance phase that
      // follows the sample and is resolved inside the chosen subrange.
      // A ladder that moved in between pushes the fine pass to a subrange
      // edge, which is why the far end drops such results.
      fine_full = adc_convert(st_reg.held, vref_pos, vref_neg);
      if (fine_full[9:`ADC_COARSE_LSB] == st_reg.coarse) begin
         fine = fine_full[4:0];                                 // RULE_06
      end else if (fine_full[9:`ADC_COARSE_LSB] > st_reg.coarse) begin
         fine = 5'h1F;
      end else begin
         fine = 5'h00;
      end

      // The falling edge closes the balance phase. It loads the output
      // register from the second stage and the first stage from the
      // fine pass, so a sample taken on one rising edge reaches the pins
      // at the falling edge of the following period.
      if (clk_fall) begin
         if (st_reg.stage2_v) begin
            st_next.dout    = st_reg.stage2;                    // RULE_17
            st_next.ovf_out = st_reg.stage2_ovf;                // RULE_09
            st_next.upd     = 1'b1;                             // RULE_03
         end
         st_next.stage2_v = 1'b0;
         if (st_reg.held_v && !st_reg.ap_busy) begin
            st_next.stage1     = {st_reg.coarse, fine};         // RULE_06
            st_next.stage1_ovf = st_reg.coarse_ovf;
            st_next.stage1_v   = 1'b1;
            st_next.held_v     = 1'b0;
         end
      end
      // With the clock parked high nothing above moves, so a pulsed clock
      // finds the converter balanced and ready for the next low phase.
   end                                                          // RULE_12

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= RESET_STATE;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign link.data     = st_reg.dout;                          // RULE_17
   assign link.overflow = st_reg.ovf_out;
   assign active_chan   = st_reg.chan;
   assign data_update   = st_reg.upd;

endmodule

`default_nettype wire

// ===== adc_host.sv
/*
 * Processor end of the converter link: makes the converter clock from clk,
 * writes multiplexer addresses and collects results.
 * Assumes the converter end holds its outputs between its own updates.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.svh"

module adc_host
   import adc_pkg::*;
(
   // System
   input  wire logic       clk,
   input  wire logic       rst,
   // Link
   adc_link_if.host        link,
   // Commands
   input  wire logic       continuous,
   input  wire logic       start,
   input  wire logic       discard,
   input  wire logic       sel_req,
   input  wire adc_chan_t  sel_chan,
   output logic            ready,
   // Results
   output adc_code_t       result_data,
   output logic            result_overflow,
   output adc_chan_t       result_chan,
   output logic            result_valid
);

   typedef struct packed {
      adc_host_state_t state;
      adc_count_t      cnt;
      logic            conv_clk;
      logic            wr_n;
      adc_chan_t       sel;
      adc_chan_t       cur_chan;
      adc_tag_t        cur;
      adc_tag_t        tag0;
      adc_tag_t        tag1;
      logic [10:0]     din_s1;
      logic [10:0]     din_s2;
      adc_code_t       res;
      logic            res_ovf;
      adc_chan_t       res_chan;
      logic            res_v;
   } adc_host_reg_t;

   localparam adc_host_reg_t RESET_STATE = '{
      state:    HOST_IDLE,
      conv_clk: 1'b1,
      wr_n:     1'b1,
      default:  '0
   };

   adc_host_reg_t st_reg;
   adc_host_reg_t st_next;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_next = st_reg;
      st_next.din_s1 = {link.overflow, link.data};
      st_next.din_s2 = st_reg.din_s1;
      st_next.res_v  = 1'b0;
      if (st_reg.cnt != '0) begin
         st_next.cnt = st_reg.cnt - adc_count_t'(1);
      end

      unique case (st_reg.state)
         HOST_IDLE: begin
            // Clock parked high between conversions keeps the far end balanced.
            if (sel_req) begin
               st_next.sel   = sel_chan;                        // RULE_16
               st_next.state = HOST_SETUP;
               st_next.cnt   = adc_count_t'(`ADC_AS_CYC - 1);
            end else if (start || continuous) begin             // RULE_12
               st_next.conv_clk = 1'b0;
               st_next.state    = HOST_LOW;
               st_next.cur      = '{valid: 1'b1, discard: discard,
                                    chan: st_reg.cur_chan};
               // A sample marked for dropping gets the shortest low time.
               st_next.cnt = discard ? adc_count_t'(`ADC_LOW_MIN_CYC - 1)
                                     : adc_count_t'(`ADC_LOW_TYP_CYC - 1); // RULE_08
            end
         end
         HOST_SETUP: begin
            if (st_reg.cnt == '0) begin
               st_next.wr_n  = 1'b0;                            // RULE_16
               st_next.state = HOST_WRITE;
               st_next.cnt   = adc_count_t'(`ADC_WR_CYC - 1);
            end
         end
         HOST_WRITE: begin
            if (st_reg.cnt == '0) begin
               st_next.wr_n     = 1'b1;
               st_next.cur_chan = st_reg.sel;
               st_next.state    = HOST_IDLE;
            end
         end
         HOST_LOW: begin
            if (st_reg.cnt == '0) begin
               st_next.conv_clk = 1'b1;                         // RULE_11
               st_next.state    = HOST_HIGH;
               st_next.cnt      = adc_count_t'(`ADC_HIGH_TYP_CYC - 1);
               // The pins now show the sample from two rising edges back.
               st_next.tag1     = st_reg.tag0;
               st_next.tag0     = st_reg.cur;
               st_next.res      = st_reg.din_s2[9:0];
               st_next.res_ovf  = st_reg.din_s2[10];
               st_next.res_chan = st_reg.tag1.chan;
               st_next.res_v    = st_reg.tag1.valid &
                                  ~st_reg.tag1.discard;         // RULE_07
            end
         end
         HOST_HIGH: begin
            if (st_reg.cnt == '0) begin
               st_next.state = HOST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= RESET_STATE;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign link.conv_clk            = st_reg.conv_clk;
   assign link.wr_n                = st_reg.wr_n;
   assign link.channel_select_bit2 = st_reg.sel[2];
   assign link.channel_select_bit1 = st_reg.sel[1];
   assign link.channel_select_bit0 = st_reg.sel[0];
   assign ready           = (st_reg.state == HOST_IDLE) && !sel_req && !start;
   assign result_data     = st_reg.res;
   assign result_overflow = st_reg.res_ovf;
   assign result_chan     = st_reg.res_chan;
   assign result_valid    = st_reg.res_v;

endmodule

`default_nettype wire

// ===== adc_link_chk.sv
/*
 * Concurrent checks on the pins between the host end and the converter end.
 * Assumes one link instance whose pins all change on edges of clk.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_link_chk
   import adc_pkg::*;
(
   // System
   input  wire logic      clk,
   input  wire logic      rst,
   // Link pins
   input  wire logic      conv_clk,
   input  wire logic      channel_select_bit2,
   input  wire logic      channel_select_bit1,
   input  wire logic      channel_select_bit0,
   input  wire logic      wr_n,
   input  wire adc_code_t data,
   input  wire logic      overflow
);
   logic [2:0] addr;
   logic [5:0] low_cnt_reg;
   logic [5:0] high_cnt_reg;

   assign addr = {channel_select_bit2, channel_select_bit1, channel_select_bit0};

   // Both counters saturate, so a long idle high phase cannot wrap round to a short one.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_reg  <= 6'h00;
         high_cnt_reg <= 6'h3F;
      end else begin
         low_cnt_reg  <= conv_clk ? 6'h00 : ((low_cnt_reg == 6'h3F) ? 6'h3F : low_cnt_reg + 6'h01);
         high_cnt_reg <= !conv_clk ? 6'h00
                                   : ((high_cnt_reg == 6'h3F) ? 6'h3F : high_cnt_reg + 6'h01);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////////////
   a_write_pulse_len : assert property (
      $fell(wr_n) |-> !wr_n [*5] ##1 wr_n) else $error("Write strobe not five cycles low.");
   a_addr_write_held : assert property (
      (!wr_n || $rose(wr_n)) |-> $stable(addr)) else $error("Address moved during write.");
   a_addr_setup_time : assert property (
      $fell(wr_n) |-> addr == $past(addr, 8)) else $error("Address setup too short.");
   a_write_idle_clock : assert property (
      !wr_n |-> conv_clk) else $error("Converter clock low during a write.");
   a_addr_conv_held : assert property (
      !conv_clk |-> $stable(addr)) else $error("Address moved during sampling.");
   a_low_phase_len : assert property (
      $rose(conv_clk) |-> (low_cnt_reg == 6'h20 || low_cnt_reg == 6'h10))
      else $error("Low phase length wrong.");
   a_high_phase_len : assert property (
      $fell(conv_clk) |-> high_cnt_reg >= 6'h20) else $error("High phase too short.");
   a_data_after_fall : assert property (
      $changed({data, overflow}) |-> !conv_clk && $past(conv_clk, 10))
      else $error("Result pins moved outside the update slot.");
   a_data_held_after : assert property (
      $changed(data) |=> $stable(data) [*8]) else $error("Result pins not held.");
endmodule

`default_nettype wire

// ===== adc_link_if.sv
/*
 * Pins between the converter and the processor that drives it.
 * Assumes both ends run from the same system clock; the pins are still
 * treated as asynchronous by each receiver.
 */
`timescale 1ns/1ps
`default_nettype none

interface adc_link_if;
   import adc_pkg::*;

   logic      conv_clk;
   logic      channel_select_bit2;
   logic      channel_select_bit1;
   logic      channel_select_bit0;
   logic      wr_n;
   adc_code_t data;
   logic      overflow;

   modport dev (
      input  conv_clk,
      input  channel_select_bit2,
      input  channel_select_bit1,
      input  channel_select_bit0,
      input  wr_n,
      output data,
      output overflow
   );

   modport host (
      output conv_clk,
      output channel_select_bit2,
      output channel_select_bit1,
      output channel_select_bit0,
      output wr_n,
      input  data,
      input  overflow
   );
endinterface

`default_nettype wire

// ===== adc_map.svh
/*
 * Timing figures and code limits of the two-step converter link.
 * Assumes a 125 MHz system clock on both ends of the link.
 */
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH

// System clock period.
`define ADC_CLK_PERIOD_NS 8

// Converter clock phase times, in ns.
`define ADC_T_LOW_MIN_NS  125
`define ADC_T_LOW_TYP_NS  250
`define ADC_T_HIGH_TYP_NS 250
// Aperture delay from the rising converter clock to the sampling instant.
`define ADC_T_AP_NS       8
// Multiplexer address setup and write pulse width.
`define ADC_T_AS_NS       80
`define ADC_T_WR_NS       40

// Least times round up to whole cycles.
`define ADC_CYC_UP(ns) (((ns) + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)

`define ADC_LOW_MIN_CYC  `ADC_CYC_UP(`ADC_T_LOW_MIN_NS)
`define ADC_LOW_TYP_CYC  `ADC_CYC_UP(`ADC_T_LOW_TYP_NS)
`define ADC_HIGH_TYP_CYC `ADC_CYC_UP(`ADC_T_HIGH_TYP_NS)
`define ADC_AP_CYC       `ADC_CYC_UP(`ADC_T_AP_NS)
`define ADC_AS_CYC       `ADC_CYC_UP(`ADC_T_AS_NS)
`define ADC_WR_CYC       `ADC_CYC_UP(`ADC_T_WR_NS)

// Code space and field positions of the result word.
`define ADC_NUM_CODES    1024
`define ADC_CODE_BITS    10
`define ADC_CODE_MAX     10'h3FF
`define ADC_COARSE_LSB   5
`define ADC_NUM_CHANNELS 8

`endif

// ===== adc_pkg.sv
/*
 * Types shared by both ends of the converter link.
 * Assumes adc_map.svh is on the include path.
 */
`default_nettype none
`include "adc_map.svh"

package adc_pkg;

   // Digital stand-in for an analog level: 0 is ground, 12'hFFF is full supply.
   typedef logic [11:0] adc_level_t;
   typedef logic [9:0]  adc_code_t;
   typedef logic [4:0]  adc_half_t;
   typedef logic [2:0]  adc_chan_t;
   typedef logic [5:0]  adc_count_t;

   typedef enum logic [2:0] {
      HOST_IDLE,
      HOST_SETUP,
      HOST_WRITE,
      HOST_LOW,
      HOST_HIGH
   } adc_host_state_t;

   // Book-keeping for one sample on its way through the converter pipeline.
   typedef struct packed {
      logic      valid;
      logic      discard;
      adc_chan_t chan;
   } adc_tag_t;

endpackage

`default_nettype wire

// ===== two_step_adc_conversion_timing_test.sv
/*
 * Self-checking bench: the host end and the converter end joined by one link.
 * Assumes adc_pkg, adc_link_if, adc_dev, adc_host and adc_link_chk are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module two_step_adc_conversion_timing_test
   import adc_pkg::*;
;

   logic             clk;
   logic             rst;
   logic             continuous;
   logic             start;
   logic             discard;
   logic             sel_req;
   adc_chan_t        sel_chan;
   logic             ready;
   adc_code_t        result_data;
   logic             result_overflow;
   adc_chan_t        result_chan;
   logic             result_valid;
   logic [7:0][11:0] ain;
   adc_level_t       vref_pos;
   adc_level_t       vref_neg;
   logic [2:0]       active_chan;
   logic             data_update;
   int               num_errors = 0;
   int               checks     = 0;
   int               num_valid  = 0;
   int               num_upd    = 0;
   adc_code_t        last_data;
   logic             last_ovf;
   adc_chan_t        last_chan;

   adc_link_if link ();

   adc_dev adc_dev_i (.clk(clk), .rst(rst), .link(link), .ain(ain), .vref_pos(vref_pos),
      .vref_neg(vref_neg), .active_chan(active_chan), .data_update(data_update));

   adc_host adc_host_i (.clk(clk), .rst(rst), .link(link), .continuous(continuous),
      .start(start), .discard(discard), .sel_req(sel_req), .sel_chan(sel_chan), .ready(ready),
      .result_data(result_data), .result_overflow(result_overflow), .result_chan(result_chan),
      .result_valid(result_valid));

   adc_link_chk adc_link_chk_i (.clk(clk), .rst(rst), .conv_clk(link.conv_clk),
      .channel_select_bit2(link.channel_select_bit2),
      .channel_select_bit1(link.channel_select_bit1),
      .channel_select_bit0(link.channel_select_bit0), .wr_n(link.wr_n),
      .data(link.data),
      .overflow(link.overflow));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   always @(posedge clk) begin
      if (result_valid === 1'b1) begin
         last_data <= result_data;
         last_ovf  <= result_overflow;
         last_chan <= result_chan;
         num_valid <= num_valid + 1;
      end
      if (data_update === 1'b1) begin
         num_upd <= num_upd + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge clk);
      while (ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      check("ready", 12'(ready), 12'h001);
   endtask

   task automatic do_write(adc_chan_t ch);
      @(posedge clk);
      sel_req  <= 1'b1;
      sel_chan <= ch;
      @(posedge clk);
      sel_req <= 1'b0;
      wait_idle();
      // The converter end needs a few cycles to synchronise the strobe.
      repeat (6) @(posedge clk);
      check("active_chan", 12'(active_chan), 12'(ch));
   endtask

   task automatic do_conv(logic disc);
      @(posedge clk);
      start   <= 1'b1;
      discard <= disc;
      @(posedge clk);
      start   <= 1'b0;
      discard <= 1'b0;
      wait_idle();
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      @(negedge clk);
      check("conv_clk", 12'(link.conv_clk), 12'h001);
      check("wr_n", 12'(link.wr_n), 12'h001);
      check("data", 12'(link.data), 12'h000);
      check("result_valid", 12'(result_valid), 12'h000);
   endtask

   // Span of 1024 levels above 12'h100, so the code is simply the level minus 12'h100.
   task automatic t_codes();
      adc_level_t vin [6] = '{12'h000, 12'h100, 12'h2A5, 12'h4FF, 12'h500, 12'hFFF};
      adc_code_t  code [6] = '{10'h000, 10'h000, 10'h1A5, 10'h3FF, 10'h3FF, 10'h3FF};
      logic       ovf [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 6; i++) begin
         do_write(3'(i));
         ain[i] <= vin[i];
         repeat (3) do_conv(1'b0);
         check("result_data", 12'(last_data), 12'(code[i]));
         check("result_ovf", 12'(last_ovf), 12'(ovf[i]));
         check("result_chan", 12'(last_chan), 12'(i));
         check("pin_data", 12'(link.data), 12'(code[i]));
         check("pin_ovf", 12'(link.overflow), 12'(ovf[i]));
      end
   endtask

   // Two earlier results drain first; of the six new samples only the first
   // clean one reaches the host, yet the pins update once per conversion.
   task automatic t_discard();
      int base;
      int ubase;
      do_write(3'h6);
      ain[6] <= 12'h3C0;
      base = num_valid;
      ubase = num_upd;
      repeat (3) do_conv(1'b1);
      repeat (3) do_conv(1'b0);
      check("valid_count", 12'(num_valid - base), 12'h003);
      check("update_count", 12'(num_upd - ubase), 12'h006);
      check("discard_data", 12'(last_data), 12'h2C0);
      check("discard_chan", 12'(last_chan), 12'h006);
   endtask

   task automatic t_continuous();
      int base;
      int n;
      do_write(3'h7);
      ain[7] <= 12'h1FF;
      base = num_valid;
      n = 0;
      @(posedge clk);
      continuous <= 1'b1;
      while (num_valid < base + 4 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      continuous <= 1'b0;
      wait_idle();
      check("cont_count", 12'(num_valid - base >= 4), 12'h001);
      check("cont_data", 12'(last_data), 12'h0FF);
      check("cont_chan", 12'(last_chan), 12'h007);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst        = 1'b1;
      continuous = 1'b0;
      start      = 1'b0;
      discard    = 1'b0;
      sel_req    = 1'b0;
      sel_chan   = 3'h0;
      ain        = {8{12'h180}};
      vref_pos   = 12'h500;
      vref_neg   = 12'h100;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_codes();
      t_discard();
      t_continuous();
      end_of_test();
   end

   // About 2000 cycles are expected; five times that means a hang.
   initial begin
      #(10000 * 8);
      num_errors++;
      end_of_test();
   end
endmodule

`default_nettype wire
